// ---- rtl/rdc_ctrl.sv ----
// rdc_ctrl: alarm comparators, request output, summer-time scheduler,
// mains-rate second tick and the control/status registers.
// assumes serial engine byte strobes and a STOP pulse on clk_sys,
// and time counters with a one-cycle update strobe.
module rdc_ctrl #(
    parameter int PULSE_LEN = rdc_pkg::PULSE_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // register strobes from the serial engine
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic bus_stop,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // time counters
    input wire rdc_pkg::rdc_time_s time_now,
    input wire logic time_update,
    output logic time_wr_en,
    output logic clock_run,
    output logic sec_tick,
    output logic summer_forward,
    output logic summer_back,
    // pins
    input wire logic mains_in,
    output logic alarm_req_n
);

    logic [7:0] int_ctrl;
    logic mains_rate_select;
    logic [7:0] st_month, st_day, st_date, st_hour;
    logic [7:0] en_month, en_day, en_date, en_hour;
    logic [7:0] alarm_reg [0:11];
    logic first_alarm_flag, second_alarm_flag;
    logic summer_time_active, rtc_fail;
    logic status_rd_pend, time_wr_pend;
    logic [1:0] flag_snap;
    logic [1:0] trig;
    logic st_hit, en_hit;
    logic align;
    rdc_pkg::rdc_irq_e irq_state;
    logic [31:0] pulse_cnt;
    logic [1:0] mains_sync;
    logic mains_prev;
    logic [5:0] mains_cnt;

    logic alarm_flag_autoclear, clock_write_unlock, alarm_pulse_mode;
    logic summer_time_enable;
    assign alarm_flag_autoclear = int_ctrl[rdc_pkg::BIT_AUTOCLEAR];
    assign clock_write_unlock = int_ctrl[rdc_pkg::BIT_UNLOCK];
    assign alarm_pulse_mode = int_ctrl[rdc_pkg::BIT_PULSE];
    assign summer_time_enable = st_month[rdc_pkg::BIT_ST_EN];

    function automatic logic [6:0] bcd_bin(input logic [7:0] b);
        bcd_bin = 7'(b[6:4]) * 7'd10 + 7'(b[3:0]);
    endfunction : bcd_bin

    function automatic logic [6:0] month_days(input logic [7:0] mo,
                                              input logic [7:0] yr);
        logic [6:0] m;
        logic leap;
        m = bcd_bin(mo);
        leap = (2'(yr[5:4] * 2'd2) + yr[1:0]) == 2'd0;
        case (m)
            7'd2: month_days = leap ? 7'd29 : 7'd28;
            7'd4, 7'd6, 7'd9, 7'd11: month_days = 7'd30;
            default: month_days = 7'd31;
        endcase
    endfunction : month_days

    // week+weekday or date match
    function automatic logic day_match(input logic [7:0] day,
                                       input logic [7:0] date,
                                       input rdc_pkg::rdc_time_s t);
        logic [6:0] d;
        logic [2:0] wk;
        logic wk_ok;
        d = bcd_bin(t.date);
        wk = day[5:3];
        wk_ok = 1'b0;
        if (wk == rdc_pkg::WEEK_LAST) begin
            wk_ok = (d + 7'd7) > month_days(t.month, t.year);
        end else if (wk != rdc_pkg::WEEK_OFF && wk <= rdc_pkg::WEEK_MAX) begin
            wk_ok = 3'((d - 7'd1) / 7'd7) + 3'd1 == wk;
        end
        if (day[rdc_pkg::BIT_PRIO]) begin
            day_match = wk_ok && (day[2:0] == t.wday[2:0]);
        end else begin
            day_match = date[5:0] == t.date[5:0];
        end
    endfunction : day_match

    // whole hour byte: format mismatch never matches
    function automatic logic sched_match(input logic [7:0] mo,
                                         input logic [7:0] day,
                                         input logic [7:0] date,
                                         input logic [7:0] hr,
                                         input rdc_pkg::rdc_time_s t);
        sched_match = (mo[4:0] == t.month[4:0])
            && day_match(day, date, t)
            && (hr == t.hour)
            && (t.min == 8'h00) && (t.sec == 8'h00);
    endfunction : sched_match

    function automatic logic field_ok(input logic [7:0] a,
                                      input logic [7:0] v,
                                      input logic [7:0] m);
        field_ok = !a[rdc_pkg::BIT_CMP_EN] || ((a & m) == (v & m));
    endfunction : field_ok

    logic wr_int, wr_status, wr_time;
    assign wr_int = reg_wr && reg_addr == rdc_pkg::ADDR_INT_CTRL;
    assign wr_status = reg_wr && reg_addr == rdc_pkg::ADDR_STATUS;
    assign wr_time = reg_wr && reg_addr <= rdc_pkg::ADDR_TIME_LAST
        && clock_write_unlock;
    assign time_wr_en = clock_write_unlock;

    // alarm comparators
    logic [1:0] alarm_en;
    assign alarm_en = {int_ctrl[rdc_pkg::BIT_EN1], int_ctrl[rdc_pkg::BIT_EN0]};
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_alarm
            localparam int B = g * rdc_pkg::ALARM_BYTES;
            logic any_en, all_ok;
            assign any_en = alarm_reg[B][7] | alarm_reg[B+1][7]
                | alarm_reg[B+2][7] | alarm_reg[B+3][7]
                | alarm_reg[B+4][7] | alarm_reg[B+5][7];
            assign all_ok =
                field_ok(alarm_reg[B], time_now.sec, rdc_pkg::MASK_SEC)
                && field_ok(alarm_reg[B+1], time_now.min, rdc_pkg::MASK_SEC)
                && field_ok(alarm_reg[B+2], time_now.hour, rdc_pkg::MASK_HOUR)
                && field_ok(alarm_reg[B+3], time_now.date, rdc_pkg::MASK_HOUR)
                && field_ok(alarm_reg[B+4], time_now.month,
                            rdc_pkg::MASK_MONTH)
                && field_ok(alarm_reg[B+5], time_now.wday, rdc_pkg::MASK_WDAY);
            // one trigger per update strobe
            assign trig[g] = time_update && alarm_en[g] && any_en
                && all_ok;
        end
    endgenerate

    // control registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            int_ctrl <= rdc_pkg::RST_INT_CTRL;
            mains_rate_select <= rdc_pkg::RST_MAINS[rdc_pkg::BIT_RATE];
            st_month <= rdc_pkg::RST_ST_MONTH;
            st_day <= rdc_pkg::RST_ST_DAY;
            st_date <= rdc_pkg::RST_ST_DATE;
            st_hour <= rdc_pkg::RST_ST_HOUR;
            en_month <= rdc_pkg::RST_EN_MONTH;
            en_day <= rdc_pkg::RST_EN_DAY;
            en_date <= rdc_pkg::RST_EN_DATE;
            en_hour <= rdc_pkg::RST_EN_HOUR;
        end else if (reg_wr) begin
            case (reg_addr)
                rdc_pkg::ADDR_INT_CTRL: int_ctrl <= reg_wdata & 8'hE3;
                rdc_pkg::ADDR_MAINS:
                    mains_rate_select <= reg_wdata[rdc_pkg::BIT_RATE];
                rdc_pkg::ADDR_ST_MONTH: st_month <= reg_wdata & 8'h9F;
                rdc_pkg::ADDR_ST_DAY: st_day <= reg_wdata & 8'h7F;
                rdc_pkg::ADDR_ST_DATE: st_date <= reg_wdata & 8'h3F;
                rdc_pkg::ADDR_ST_HOUR: st_hour <= reg_wdata & 8'hBF;
                rdc_pkg::ADDR_EN_MONTH: en_month <= reg_wdata & 8'h1F;
                rdc_pkg::ADDR_EN_DAY: en_day <= reg_wdata & 8'h7F;
                rdc_pkg::ADDR_EN_DATE: en_date <= reg_wdata & 8'h3F;
                rdc_pkg::ADDR_EN_HOUR: en_hour <= reg_wdata & 8'hBF;
                default: ;
            endcase
        end
    end

    // alarm bytes
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < 12; i++) begin
                alarm_reg[i] <= (i % 6 == 3 || i % 6 == 4)
                    ? rdc_pkg::RST_ALARM_DATE : rdc_pkg::RST_ALARM_OTHER;
            end
        end else if (reg_wr && reg_addr >= rdc_pkg::ADDR_ALARM_BASE
                     && reg_addr <= rdc_pkg::ADDR_ALARM_LAST) begin
            alarm_reg[4'(reg_addr - rdc_pkg::ADDR_ALARM_BASE)] <= reg_wdata;
        end
    end

    // status read tracking for autoclear
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status_rd_pend <= 1'b0;
            flag_snap <= 2'b00;
        end else if (bus_stop) begin
            status_rd_pend <= 1'b0;
            flag_snap <= 2'b00;
        end else if (reg_rd && reg_addr == rdc_pkg::ADDR_STATUS) begin
            status_rd_pend <= 1'b1;
            // only flags seen by the read may be wiped
            flag_snap <= flag_snap | {second_alarm_flag, first_alarm_flag};
        end
    end

    // alarm flags: set beats clear
    logic [1:0] clr_auto;
    assign clr_auto = (bus_stop && status_rd_pend && alarm_flag_autoclear)
        ? flag_snap : 2'b00;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            first_alarm_flag <= 1'b0;
            second_alarm_flag <= 1'b0;
        end else begin
            if (trig[0]) begin
                first_alarm_flag <= 1'b1;
            end else if ((wr_status && !reg_wdata[rdc_pkg::BIT_FLAG0])
                         || clr_auto[0]) begin
                first_alarm_flag <= 1'b0;
            end
            if (trig[1]) begin
                second_alarm_flag <= 1'b1;
            end else if ((wr_status && !reg_wdata[rdc_pkg::BIT_FLAG1])
                         || clr_auto[1]) begin
                second_alarm_flag <= 1'b0;
            end
        end
    end

    // alarm request output
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_state <= rdc_pkg::RDC_IRQ_IDLE;
            pulse_cnt <= 32'h0000_0000;
        end else begin
            case (irq_state)
                rdc_pkg::RDC_IRQ_IDLE: begin
                    if (alarm_pulse_mode && |trig) begin
                        irq_state <= rdc_pkg::RDC_IRQ_PULSE;
                        pulse_cnt <= 32'(PULSE_LEN - 1);
                    end
                end
                rdc_pkg::RDC_IRQ_PULSE: begin
                    if (alarm_pulse_mode && |trig) begin
                        pulse_cnt <= 32'(PULSE_LEN - 1);
                    end else if (pulse_cnt == 32'h0000_0000) begin
                        irq_state <= rdc_pkg::RDC_IRQ_IDLE;
                    end else begin
                        pulse_cnt <= pulse_cnt - 32'h0000_0001;
                    end
                end
                default: irq_state <= rdc_pkg::RDC_IRQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            alarm_req_n <= 1'b1;
        end else if (alarm_pulse_mode) begin
            // pulsing never waits on software
            alarm_req_n <= irq_state != rdc_pkg::RDC_IRQ_PULSE;
        end else begin
            alarm_req_n <= !(first_alarm_flag || second_alarm_flag);
        end
    end

    // summer-time scheduler
    assign st_hit = time_update && summer_time_enable && !summer_time_active
        && sched_match(st_month, st_day, st_date, st_hour, time_now);
    assign en_hit = time_update && summer_time_enable && summer_time_active
        && sched_match(en_month, en_day, en_date, en_hour, time_now);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            summer_time_active <= 1'b0;
            summer_forward <= 1'b0;
            summer_back <= 1'b0;
        end else begin
            summer_forward <= st_hit;
            summer_back <= en_hit;
            if (!summer_time_enable || en_hit) begin
                summer_time_active <= 1'b0;
            end else if (st_hit
                         || (wr_status && reg_wdata[rdc_pkg::BIT_ACTIVE])) begin
                summer_time_active <= 1'b1;
            end
        end
    end

    // time writes, fail flag and clock start
    assign align = bus_stop && time_wr_pend;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            time_wr_pend <= 1'b0;
            clock_run <= 1'b0;
            rtc_fail <= 1'b1;
        end else begin
            if (wr_time) begin
                time_wr_pend <= 1'b1;
                rtc_fail <= 1'b0;
            end else if (bus_stop) begin
                time_wr_pend <= 1'b0;
            end
            if (align) begin
                clock_run <= 1'b1;
            end
        end
    end

    // edge detect reads only the second stage
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mains_sync <= 2'b00;
            mains_prev <= 1'b0;
        end else begin
            mains_sync <= {mains_sync[0], mains_in};
            mains_prev <= mains_sync[1];
        end
    end

    logic mains_rise;
    logic [5:0] mains_last;
    assign mains_rise = mains_sync[1] && !mains_prev;
    assign mains_last = (mains_rate_select ? rdc_pkg::MAINS_50
        : rdc_pkg::MAINS_60) - 6'd1;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mains_cnt <= 6'd0;
            sec_tick <= 1'b0;
        end else begin
            sec_tick <= 1'b0;
            if (align) begin
                mains_cnt <= 6'd0;
            end else if (mains_rise) begin
                if (mains_cnt >= mains_last) begin
                    mains_cnt <= 6'd0;
                    sec_tick <= clock_run;
                end else begin
                    mains_cnt <= mains_cnt + 6'd1;
                end
            end
        end
    end

    // read data
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= 8'h00;
            reg_hit <= 1'b0;
        end else if (reg_rd) begin
            reg_hit <= 1'b1;
            case (reg_addr)
                rdc_pkg::ADDR_STATUS: reg_rdata <= {1'b0, summer_time_active,
                    second_alarm_flag, first_alarm_flag, 3'b000, rtc_fail};
                rdc_pkg::ADDR_INT_CTRL: reg_rdata <= int_ctrl;
                rdc_pkg::ADDR_MAINS: reg_rdata <= {mains_rate_select, 7'h00};
                rdc_pkg::ADDR_ST_MONTH: reg_rdata <= st_month;
                rdc_pkg::ADDR_ST_DAY: reg_rdata <= st_day;
                rdc_pkg::ADDR_ST_DATE: reg_rdata <= st_date;
                rdc_pkg::ADDR_ST_HOUR: reg_rdata <= st_hour;
                rdc_pkg::ADDR_EN_MONTH: reg_rdata <= en_month;
                rdc_pkg::ADDR_EN_DAY: reg_rdata <= en_day;
                rdc_pkg::ADDR_EN_DATE: reg_rdata <= en_date;
                rdc_pkg::ADDR_EN_HOUR: reg_rdata <= en_hour;
                default: begin
                    if (reg_addr >= rdc_pkg::ADDR_ALARM_BASE
                        && reg_addr <= rdc_pkg::ADDR_ALARM_LAST) begin
                        reg_rdata <= alarm_reg[4'(reg_addr
                            - rdc_pkg::ADDR_ALARM_BASE)];
                    end else begin
                        reg_rdata <= 8'h00;
                        reg_hit <= 1'b0;
                    end
                end
            endcase
        end
    end

endmodule : rdc_ctrl

// ---- inc/rdc_pkg.sv ----
// rdc_pkg: register map, field positions, reset values and timing counts
// for alarm, summer-time and mains-rate control.
// assumes the serial engine and the time counters share clk_sys.
//
// Function
// - autoclear wipes alarm flags after status read+STOP
// - time writes only while unlock bit set
// - valid time write STOP starts clock, aligns tick
// - pulse mode: 250 ms low pulse per trigger
// - level mode: request low until both flags clear
// - second alarm enable gates second comparator
// - first alarm enable gates first comparator
// - rate select: 0 is 60 Hz, 1 is 50 Hz
// - summer time only while enable bit set
// - start priority bit picks week+weekday over date
// - start week 1..5, 7 last, 0 off
// - start transition advances clock one hour
// - end priority bit picks week+weekday over date
// - end week 1..5, 7 last, 0 off
// - end transition sets clock back one hour
// - alarm byte mirrors time field, top bit enables
// - trigger when all enabled fields equal time
// - single event: flag set, request low till cleared
// - pulse mode repeats on every alarm occurrence
// - pulse mode still sets flag, no clear needed
// - host write to alarm flag only clears
// - active flag set at start, cleared end/disable
package rdc_pkg;

    // register offsets
    localparam logic [7:0] ADDR_TIME_LAST = 8'h07;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_INT_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_MAINS = 8'h13;
    localparam logic [7:0] ADDR_ST_MONTH = 8'h15;
    localparam logic [7:0] ADDR_ST_DAY = 8'h16;
    localparam logic [7:0] ADDR_ST_DATE = 8'h17;
    localparam logic [7:0] ADDR_ST_HOUR = 8'h18;
    localparam logic [7:0] ADDR_EN_MONTH = 8'h19;
    localparam logic [7:0] ADDR_EN_DAY = 8'h1A;
    localparam logic [7:0] ADDR_EN_DATE = 8'h1B;
    localparam logic [7:0] ADDR_EN_HOUR = 8'h1C;
    localparam logic [7:0] ADDR_ALARM_BASE = 8'h1D;
    localparam logic [7:0] ADDR_ALARM_LAST = 8'h28;
    localparam int ALARM_BYTES = 6;

    // field positions
    localparam int BIT_AUTOCLEAR = 7;
    localparam int BIT_UNLOCK = 6;
    localparam int BIT_PULSE = 5;
    localparam int BIT_EN1 = 1;
    localparam int BIT_EN0 = 0;
    localparam int BIT_RATE = 7;
    localparam int BIT_ST_EN = 7;
    localparam int BIT_PRIO = 6;
    localparam int BIT_ACTIVE = 6;
    localparam int BIT_FLAG1 = 5;
    localparam int BIT_FLAG0 = 4;
    localparam int BIT_FAIL = 0;
    localparam int BIT_CMP_EN = 7;

    // compare masks and week codes
    localparam logic [7:0] MASK_SEC = 8'h7F;
    localparam logic [7:0] MASK_HOUR = 8'h3F;
    localparam logic [7:0] MASK_MONTH = 8'h1F;
    localparam logic [7:0] MASK_WDAY = 8'h07;
    localparam logic [2:0] WEEK_OFF = 3'h0;
    localparam logic [2:0] WEEK_LAST = 3'h7;
    localparam logic [2:0] WEEK_MAX = 3'h5;

    // reset values
    localparam logic [7:0] RST_INT_CTRL = 8'h01;
    localparam logic [7:0] RST_MAINS = 8'h00;
    localparam logic [7:0] RST_ST_MONTH = 8'h04;
    localparam logic [7:0] RST_ST_DAY = 8'h00;
    localparam logic [7:0] RST_ST_DATE = 8'h01;
    localparam logic [7:0] RST_ST_HOUR = 8'h02;
    localparam logic [7:0] RST_EN_MONTH = 8'h10;
    localparam logic [7:0] RST_EN_DAY = 8'h00;
    localparam logic [7:0] RST_EN_DATE = 8'h01;
    localparam logic [7:0] RST_EN_HOUR = 8'h02;
    localparam logic [7:0] RST_ALARM_DATE = 8'h01;
    localparam logic [7:0] RST_ALARM_OTHER = 8'h00;

    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int PULSE_MS = 250;
    localparam int PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS;
    localparam logic [5:0] MAINS_60 = 6'd60;
    localparam logic [5:0] MAINS_50 = 6'd50;

    // current time, register coding
    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
        logic [7:0] wday;
    } rdc_time_s;

    typedef enum logic [0:0] {
        RDC_IRQ_IDLE = 1'b0,
        RDC_IRQ_PULSE = 1'b1
    } rdc_irq_e;

endpackage : rdc_pkg

// ---- verif/rdc_monitor.sv ----
// rdc_monitor: port assertions for rdc_ctrl.
// assumes one clk_sys domain, synchronous reset.
module rdc_monitor #(
    parameter int PULSE_LEN = 20
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // register strobes
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic bus_stop,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit,
    // time and pins
    input wire logic time_update,
    input wire logic time_wr_en,
    input wire logic clock_run,
    input wire logic sec_tick,
    input wire logic summer_forward,
    input wire logic summer_back,
    input wire logic alarm_req_n
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    property p_unlock;
        reg_wr && reg_addr == 8'h0C |=> time_wr_en == $past(reg_wdata[6]);
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock bit");
    property p_locked_rd;
        reg_rd && reg_addr < 8'h08 |=> !reg_hit && reg_rdata == 8'h00;
    endproperty
    a_locked_rd: assert property (p_locked_rd) else $error("time rd");
    property p_start;
        $rose(clock_run) |-> $past(bus_stop);
    endproperty
    a_start: assert property (p_start) else $error("start w/o stop");
    property p_tick;
        sec_tick |-> clock_run ##1 !sec_tick;
    endproperty
    a_tick: assert property (p_tick) else $error("tick");
    property p_fwd;
        summer_forward |-> $past(time_update) && !summer_back;
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward pulse");
    property p_back;
        summer_back |-> $past(time_update) ##1 !summer_back;
    endproperty
    a_back: assert property (p_back) else $error("back pulse");
    property p_req;
        $fell(alarm_req_n) |-> $past(time_update, 2);
    endproperty
    a_req: assert property (p_req) else $error("request cause");
    property p_status;
        reg_rd && reg_addr == 8'h08 |=> reg_hit && reg_rdata[3:1] == 3'h0;
    endproperty
    a_status: assert property (p_status) else $error("status");
endmodule : rdc_monitor

bind rdc_ctrl rdc_monitor #(.PULSE_LEN(PULSE_LEN)) mon_u (
    .clk_sys(clk_sys), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .bus_stop(bus_stop),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .time_update(time_update),
    .time_wr_en(time_wr_en), .clock_run(clock_run), .sec_tick(sec_tick),
    .summer_forward(summer_forward), .summer_back(summer_back),
    .alarm_req_n(alarm_req_n));

// ---- verif/rdc_time_model.sv ----
// rdc_time_model: stand-in for the time counters.
// assumes the bench pulses load for one cycle with a new time.
module rdc_time_model (
    // clock
    input wire logic clk_sys,
    // bench side
    input wire rdc_pkg::rdc_time_s load_time,
    input wire logic load,
    // block side
    input wire logic summer_forward,
    input wire logic summer_back,
    output rdc_pkg::rdc_time_s time_now,
    output logic time_update
);
    timeunit 1ns;
    timeprecision 1ns;
    // hour arithmetic kept binary: tests avoid bcd carries
    always @(posedge clk_sys) begin
        time_update <= load;
        if (load) begin
            time_now <= load_time;
        end else if (summer_forward) begin
            time_now.hour <= time_now.hour + 8'h01;
        end else if (summer_back) begin
            time_now.hour <= time_now.hour - 8'h01;
        end
    end
endmodule : rdc_time_model

// ---- verif/tb.sv ----
// tb: self-checking bench for rdc_ctrl.
// assumes inputs change on the falling edge of clk_sys.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PL = 20;
    logic clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0, bus_stop = 0;
    logic mains_in = 0, load = 0, reg_hit, time_wr_en, clock_run, sec_tick;
    logic summer_forward, summer_back, alarm_req_n, time_update;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, got, v;
    logic [7:0] ra [$] = '{8'h0C, 8'h13, 8'h15, 8'h16, 8'h17, 8'h18,
        8'h19, 8'h1A, 8'h1B, 8'h1C};
    logic [7:0] rv [$] = '{8'h01, 8'h00, 8'h04, 8'h00, 8'h01, 8'h02,
        8'h10, 8'h00, 8'h01, 8'h02};
    logic [7:0] rm [$] = '{8'hE3, 8'h80, 8'h9F, 8'h7F, 8'h3F, 8'hBF,
        8'h1F, 8'h7F, 8'h3F, 8'hBF};
    rdc_pkg::rdc_time_s load_time = '0, time_now;
    int errors = 0, n_tests = 0, k;
    `define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
        errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
    always #50 clk_sys = ~clk_sys;
    always #400 mains_in = ~mains_in;
    rdc_ctrl #(.PULSE_LEN(PL)) dut_u (
        .clk_sys(clk_sys), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .bus_stop(bus_stop),
        .reg_rdata(reg_rdata), .reg_hit(reg_hit), .time_now(time_now),
        .time_update(time_update), .time_wr_en(time_wr_en),
        .clock_run(clock_run), .sec_tick(sec_tick),
        .summer_forward(summer_forward), .summer_back(summer_back),
        .mains_in(mains_in), .alarm_req_n(alarm_req_n));
    rdc_time_model tm_u (
        .clk_sys(clk_sys), .load_time(load_time), .load(load),
        .summer_forward(summer_forward), .summer_back(summer_back),
        .time_now(time_now), .time_update(time_update));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        cyc(1);
        reg_wr = 0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        cyc(1);
        reg_addr = a;
        reg_rd = 1;
        cyc(1);
        reg_rd = 0;
        got = reg_rdata;
    endtask : rd
    task automatic stop();
        cyc(1);
        bus_stop = 1;
        cyc(1);
        bus_stop = 0;
    endtask : stop
    // one time update, min and year zero
    task automatic upd(input logic [7:0] s, h, d, m, w);
        cyc(1);
        load_time = '{s, 8'h00, h, d, m, 8'h00, w};
        load = 1;
        cyc(1);
        load = 0;
        cyc(3);
    endtask : upd
    task automatic gap(output int n);
        @(negedge sec_tick);
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (sec_tick !== 1'b1 && n < 2000);
    endtask : gap
    // cycles the request stays low
    task automatic lowlen(output int n);
        n = 0;
        while (alarm_req_n === 1'b0 && n < 5000) begin
            cyc(1);
            n++;
        end
    endtask : lowlen
    task automatic stop_test();
        $display("errors %0d tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (40000) @(posedge clk_sys);
        errors++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h63b2e93a));
        cyc(6);
        reset = 0;
        foreach (ra[i]) begin
            rd(ra[i]);
            `CHK("reset val", rv[i], got)
            v = 8'($urandom);
            wr(ra[i], v);
            rd(ra[i]);
            `CHK("readback", v & rm[i], got)
            wr(ra[i], rv[i]);
        end
        rd(8'h03);
        `CHK("time hit", 1'b0, reg_hit)
        rd(8'h09);
        `CHK("unmapped hit", 1'b0, reg_hit)
        wr(8'h00, 8'h12);
        stop();
        `CHK("locked run", 1'b0, clock_run)
        wr(8'h0C, 8'h40);
        wr(8'h00, 8'h00);
        stop();
        `CHK("clock run", 1'b1, clock_run)
        gap(k);
        `CHK("60 Hz gap", 480, k)
        wr(8'h13, 8'h80);
        gap(k);
        `CHK("50 Hz gap", 400, k)
        wr(8'h13, 8'h00);
        // level mode, seconds 30
        wr(8'h1D, 8'hB0);
        wr(8'h23, 8'hB0);
        wr(8'h0C, 8'h41);
        upd(8'h29, 8'h09, 8'h01, 8'h01, 8'h00);
        `CHK("no match", 1'b1, alarm_req_n)
        upd(8'h30, 8'h09, 8'h01, 8'h01, 8'h00);
        `CHK("level low", 1'b0, alarm_req_n)
        rd(8'h08);
        `CHK("flag0", 8'h10, got)
        stop();
        wr(8'h08, 8'h30);
        rd(8'h08);
        `CHK("no autoclear, ones", 8'h10, got)
        wr(8'h08, 8'h00);
        cyc(2);
        `CHK("released", 1'b1, alarm_req_n)
        wr(8'h0C, 8'h40);
        upd(8'h30, 8'h09, 8'h01, 8'h01, 8'h00);
        `CHK("disabled", 1'b1, alarm_req_n)
        wr(8'h0C, 8'h43);
        upd(8'h30, 8'h09, 8'h01, 8'h01, 8'h00);
        wr(8'h08, 8'h20);
        rd(8'h08);
        `CHK("flag1 kept", 8'h20, got)
        `CHK("one flag holds", 1'b0, alarm_req_n)
        wr(8'h0C, 8'hC3);
        rd(8'h08);
        stop();
        rd(8'h08);
        `CHK("autoclear", 8'h00, got)
        // pulse mode, no clearing
        wr(8'h0C, 8'h61);
        repeat (2) begin
            upd(8'h30, 8'h09, 8'h01, 8'h01, 8'h00);
            lowlen(k);
            `CHK("pulse len", PL - 1, k)
            rd(8'h08);
            `CHK("pulse flag", 8'h10, got)
        end
        cyc(30);
        `CHK("one per update", 1'b1, alarm_req_n)
        // summer hours kept in clock hour format
        upd(8'h00, 8'h02, 8'h01, 8'h04, 8'h00);
        `CHK("st off", 8'h02, time_now.hour)
        wr(8'h15, 8'h84);
        upd(8'h00, 8'h02, 8'h01, 8'h04, 8'h00);
        `CHK("forward", 8'h03, time_now.hour)
        rd(8'h08);
        `CHK("active", 1'b1, got[6])
        upd(8'h00, 8'h02, 8'h01, 8'h10, 8'h00);
        `CHK("back", 8'h01, time_now.hour)
        wr(8'h16, 8'h4B);
        upd(8'h00, 8'h02, 8'h01, 8'h04, 8'h00);
        `CHK("weekday prio", 8'h02, time_now.hour)
        wr(8'h16, 8'h7B);
        upd(8'h00, 8'h02, 8'h28, 8'h04, 8'h03);
        `CHK("last week", 8'h03, time_now.hour)
        wr(8'h15, 8'h04);
        rd(8'h08);
        `CHK("disable", 1'b0, got[6])
        stop_test();
    end
endmodule : tb
